// ===== shared/slc_pkg.sv
// Sleep controller shared constants and carrier types.
// Assumes one peripheral clock and synchronous active-high reset.
package slc_pkg;

   // Sleep state select encoding
   localparam logic [1:0] SEL_IDLE      = 2'h0;
   localparam logic [1:0] SEL_STANDBY   = 2'h1;
   localparam logic [1:0] SEL_POWERDOWN = 2'h2;

   // Controller states, one-hot
   typedef enum logic [4:0] {
      ST_ACTIVE    = 5'h01,
      ST_IDLE      = 5'h02,
      ST_STANDBY   = 5'h04,
      ST_POWERDOWN = 5'h08,
      ST_WAKE      = 5'h10
   } slc_state_e;

   // Wake latency in peripheral clock cycles
   localparam int unsigned WAKE_CYCLES = 6;
   localparam int unsigned WAKE_CW     = 3;
   localparam logic [WAKE_CW-1:0] WAKE_LAST = WAKE_CW'(WAKE_CYCLES - 1);
   localparam logic [WAKE_CW-1:0] CNT_ZERO  = 3'h0;

   // Wake request sources
   typedef struct packed {
      logic pin;        // Pin change / pin interrupt
      logic twi_match;  // Two-wire address match
      logic cap_timer;  // Capture timer interrupt
      logic uart_sof;   // Serial start of frame
      logic rtc;        // Real-time counter interrupt
      logic periodic_interrupt_timer;        // Periodic interrupt timer
      logic adc;        // Converter window interrupt
      logic other;      // Any other interrupt
   } slc_wake_s;

   // Run-in-standby settings per unit
   typedef struct packed {
      logic uart;
      logic rtc;
      logic adc;
      logic cap_timer;
      logic misc;
   } slc_stby_s;

   // Clock gate enables
   typedef struct packed {
      logic cpu;
      logic per;
      logic rtc;
      logic adc;
      logic wdt;
      logic periodic_interrupt_timer;
      logic main_osc;
   } slc_clk_s;

endpackage

// ===== src/slc_wake_filter.sv
// Wake source filter: which enabled requests may wake from each sleep state.
// Assumes requests are already masked by their interrupt enables.
`timescale 1ns/100ps
module slc_wake_filter (
   input  wire slc_pkg::slc_wake_s req,
   input  wire slc_pkg::slc_stby_s stby,
   input  wire logic               in_idle,
   input  wire logic               in_standby,
   input  wire logic               in_powerdown,
   output logic                    wake
);
   logic any_req;
   logic stby_req;
   logic pd_req;

   assign any_req  = |req;
   assign stby_req = req.pin | req.twi_match | req.cap_timer
                   | (req.uart_sof & stby.uart) | (req.rtc & stby.rtc);
   assign pd_req   = req.pin | req.twi_match;
   assign wake     = (in_idle & any_req) | (in_standby & stby_req)
                   | (in_powerdown & pd_req);
endmodule

// ===== src/slc_clock_gate.sv
// Clock gate enable decode per controller state.
// Assumes gates downstream stop a domain while its enable is low.
`timescale 1ns/100ps
module slc_clock_gate (
   input  wire slc_pkg::slc_state_e state,
   input  wire slc_pkg::slc_stby_s  stby,
   input  wire logic                wake_osc_up,
   output slc_pkg::slc_clk_s        gates
);
   always_comb begin
      gates = '1;
      case (state)
         slc_pkg::ST_ACTIVE: begin
            gates = '1;
         end
         slc_pkg::ST_IDLE: begin
            gates.cpu = 1'b0;
         end
         slc_pkg::ST_STANDBY: begin
            gates.cpu      = 1'b0;
            gates.per      = stby.misc | stby.uart | stby.cap_timer;
            gates.rtc      = stby.rtc;
            gates.adc      = stby.adc;
            gates.main_osc = stby.misc | stby.uart | stby.adc | stby.cap_timer;
         end
         slc_pkg::ST_POWERDOWN: begin
            gates.cpu      = 1'b0;
            gates.per      = 1'b0;
            gates.rtc      = 1'b0;
            gates.adc      = 1'b0;
            gates.main_osc = 1'b0;
         end
         slc_pkg::ST_WAKE: begin
            gates.cpu      = 1'b0;
            gates.main_osc = 1'b1;
            gates.per      = wake_osc_up;
         end
         default: begin
            gates = '1;
         end
      endcase
   end
endmodule

// ===== src/slc_sleep_controller.sv
// Sleep controller: Active, Idle, Standby and Power-Down sequencing.
// Assumes the core raises sleep_instr for one cycle on a sleep instruction,
// wake requests arrive masked by their enables, and reset covers all sources.
//
// Contract
// - Five states only: Active, Idle, Standby, Power-Down plus Wake.
// - Sleep starts only on the sleep instruction with allow bit set.
// - Sleep halts the core and gates excluded clock domains.
// - Enabled wake interrupt returns to Active, handler runs, then resumes.
// - Any reset ends sleep; core restarts at reset vector.
// - Register file, SRAM and peripheral registers kept through sleep.
// - Without enabled wake interrupt, only reset or debug halt request ends sleep.
// - Debug halt request during sleep forces return to Active.
// - Run-time debug without halt leaves sleep behaviour unchanged.
// - Idle stops only the processor clock.
// - Every interrupt wakes from Idle.
// - Standby keeps a unit clocked only if its run-in-standby is set.
// - Standby wakes on pin, address match, capture timer, gated SOF/RTC.
// - Converter may run on its own in Standby.
// - Power-Down keeps only watchdog and periodic timer running.
// - Power-Down wakes only on pin change or address match.
// - Controller runs on the peripheral clock.
// - Wake takes six clock cycles, held longer until the main source is up, no start-up wait in Idle.
`timescale 1ns/100ps
module slc_sleep_controller (
   input  wire logic               mclk,
   input  wire logic               reset,
   input  wire logic               sleep_allow_bit,
   input  wire logic [1:0]         sleep_state_select,
   input  wire logic               sleep_instr,
   input  wire slc_pkg::slc_wake_s wake_req,
   input  wire slc_pkg::slc_stby_s run_in_standby,
   input  wire logic               debug_halt_req,
   input  wire logic               debug_run,
   input  wire logic               main_osc_ready,
   output logic                    core_halt,
   output logic                    wake_done,
   output logic [4:0]              state_onehot,
   output slc_pkg::slc_clk_s       clk_gates,
   output logic                    retain
);
   slc_pkg::slc_state_e state_q;
   slc_pkg::slc_state_e state_d;
   logic [slc_pkg::WAKE_CW-1:0] cnt_q;
   logic        from_idle_q;
   logic        wake;
   logic        osc_ok;
   logic        cnt_done;
   logic        wake_done_q;
   logic        in_idle;
   logic        in_stby;
   logic        in_pd;

   assign in_idle = (state_q == slc_pkg::ST_IDLE);
   assign in_stby = (state_q == slc_pkg::ST_STANDBY);
   assign in_pd   = (state_q == slc_pkg::ST_POWERDOWN);

   slc_wake_filter u_filter (
      .req          (wake_req),
      .stby         (run_in_standby),
      .in_idle      (in_idle),
      .in_standby   (in_stby),
      .in_powerdown (in_pd),
      .wake         (wake)
   );

   // Idle never stops the main source, so no start-up wait
   assign osc_ok   = from_idle_q | main_osc_ready;
   assign cnt_done = (cnt_q == slc_pkg::WAKE_LAST) && osc_ok;

   slc_clock_gate u_gate (
      .state       (state_q),
      .stby        (run_in_standby),
      .wake_osc_up (osc_ok),
      .gates       (clk_gates)
   );

   // debug_run deliberately unused in the sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         slc_pkg::ST_ACTIVE: begin
            if (sleep_instr && sleep_allow_bit) begin
               case (sleep_state_select)
                  slc_pkg::SEL_IDLE:      state_d = slc_pkg::ST_IDLE;
                  slc_pkg::SEL_STANDBY:   state_d = slc_pkg::ST_STANDBY;
                  slc_pkg::SEL_POWERDOWN: state_d = slc_pkg::ST_POWERDOWN;
                  default:                state_d = slc_pkg::ST_ACTIVE;
               endcase
            end
         end
         slc_pkg::ST_IDLE, slc_pkg::ST_STANDBY, slc_pkg::ST_POWERDOWN: begin
            if (wake || debug_halt_req) begin
               state_d = slc_pkg::ST_WAKE;
            end
         end
         slc_pkg::ST_WAKE: begin
            if (cnt_done) begin
               state_d = slc_pkg::ST_ACTIVE;
            end
         end
         default: begin
            state_d = slc_pkg::ST_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= slc_pkg::ST_ACTIVE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_q <= slc_pkg::CNT_ZERO;
      end else if (state_q != slc_pkg::ST_WAKE) begin
         cnt_q <= slc_pkg::CNT_ZERO;
      end else if (cnt_q != slc_pkg::WAKE_LAST) begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         from_idle_q <= 1'b0;
      end else if (state_q == slc_pkg::ST_ACTIVE) begin
         from_idle_q <= (sleep_state_select == slc_pkg::SEL_IDLE);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         wake_done_q <= 1'b0;
      end else begin
         wake_done_q <= (state_q == slc_pkg::ST_WAKE) && cnt_done;
      end
   end

   assign core_halt    = (state_q != slc_pkg::ST_ACTIVE);
   assign wake_done    = wake_done_q;
   assign state_onehot = state_q;
   assign retain       = 1'b1;
endmodule

// ===== verification/slc_core_model.sv
// Core model: issues the sleep instruction, counts resumes.
// Assumes the core stalls while core_halt is high.
`timescale 1ns/100ps
module slc_core_model (
   input  wire logic  mclk,
   input  wire logic  reset,
   input  wire logic  go,
   input  wire logic  core_halt,
   input  wire logic  wake_done,
   output logic       sleep_instr,
   output logic [7:0] resumes
);
   always_ff @(posedge mclk) begin
      sleep_instr <= go && !core_halt && !sleep_instr;
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         resumes <= 8'h00;
      end else if (wake_done) begin
         resumes <= resumes + 8'h01;
      end
   end
endmodule

// ===== verification/slc_sleep_controller_monitor.sv
// Port checker for the sleep controller.
// Bound to the controller top; sees its ports only.
`timescale 1ns/100ps
module slc_sleep_controller_monitor (
   input wire logic               mclk,
   input wire logic               reset,
   input wire logic               sleep_allow_bit,
   input wire logic [1:0]         sleep_state_select,
   input wire logic               sleep_instr,
   input wire slc_pkg::slc_wake_s wake_req,
   input wire slc_pkg::slc_stby_s run_in_standby,
   input wire logic               debug_halt_req,
   input wire logic               debug_run,
   input wire logic               main_osc_ready,
   input wire logic               core_halt,
   input wire logic               wake_done,
   input wire logic [4:0]         state_onehot,
   input wire slc_pkg::slc_clk_s  clk_gates,
   input wire logic               retain
);
   wire logic [4:0] s;
   wire logic       go;
   assign s = state_onehot;
   assign go = sleep_instr && sleep_allow_bit && sleep_state_select != 2'h3;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_sleep_needs_instr: assert property (s == 5'h01 && !go |=> s == 5'h01)
      else $error("slept without instruction");
   a_sleep_enters: assert property (s == 5'h01 && go |=> core_halt &&
      s == 5'h02 << $past(sleep_state_select)) else $error("wrong sleep state");
   a_idle_gates: assert property (s == 5'h02 |-> clk_gates == 7'h3F)
      else $error("idle gates");
   a_stby_gates: assert property (s == 5'h04 |-> !clk_gates.cpu &&
      clk_gates.rtc == run_in_standby.rtc && clk_gates.adc == run_in_standby.adc)
      else $error("standby gates");
   a_pd_gates: assert property (s == 5'h08 |-> clk_gates == 7'h06)
      else $error("power-down gates");
   a_pd_wake_only: assert property (s == 5'h08 && !debug_halt_req &&
      !wake_req.pin && !wake_req.twi_match |=> s == 5'h08) else $error("bad wake");
   a_debug_wake: assert property (s[3:1] != 3'h0 && debug_halt_req |=> s == 5'h10)
      else $error("debug wake");
   a_idle_wake_time: assert property (s == 5'h02 && wake_req.other |=>
      s == 5'h10 [*6] ##1 (s == 5'h01 && wake_done)) else $error("wake time");
   c_idle: cover property (s == 5'h02);
   c_stby: cover property (s == 5'h04);
   c_pd: cover property (s == 5'h08);
   c_wake_done: cover property (wake_done);
endmodule
bind slc_sleep_controller slc_sleep_controller_monitor slc_sleep_controller_monitor_i (.*);

// ===== verification/slc_sleep_controller_tb_top.sv
// Testbench for the sleep controller with a core model.
// Assumes 40 MHz mclk and synchronous active-high reset.
`timescale 1ns/100ps
module slc_sleep_controller_tb_top;
   logic mclk = 0, reset = 1, allow = 0, go = 0, dbg = 0, osc = 1, si, halt, done;
   logic               drun = 0, ret;
   logic [1:0]         sel = 2'h0;
   logic [4:0]         st;
   logic [7:0]         res;
   slc_pkg::slc_wake_s wq = '0;
   slc_pkg::slc_stby_s rs = '0;
   slc_pkg::slc_clk_s  g;
   int err_total = 0, tests_run = 0;
   always #12.5 mclk = ~mclk;
   slc_core_model slc_core_model_i (.mclk(mclk), .reset(reset), .go(go), .core_halt(halt),
      .wake_done(done), .sleep_instr(si), .resumes(res));
   slc_sleep_controller slc_sleep_controller_i (.mclk(mclk), .reset(reset),
      .sleep_allow_bit(allow), .sleep_state_select(sel), .sleep_instr(si), .wake_req(wq),
      .run_in_standby(rs), .debug_halt_req(dbg), .debug_run(drun), .main_osc_ready(osc),
      .core_halt(halt), .wake_done(done), .state_onehot(st), .clk_gates(g), .retain(ret));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic sleep(input logic [1:0] m);
      sel = m;
      go = 1;
      tick(1);
      go = 0;
      tick(2);
   endtask
   task automatic wait_act(output int n);
      n = 0;
      while (st !== 5'h01 && n < 30) begin
         tick(1);
         n++;
      end
      if (st !== 5'h01) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   task automatic sc_refuse();
      sleep(2'h0);
      chk("no_allow", 8'(st), 8'h01);
      allow = 1;
      sleep(2'h3);
      chk("sel3", 8'(st), 8'h01);
   endtask
   task automatic sc_idle();
      int n;
      sleep(2'h0);
      chk("idle", 8'({st, halt}), 8'h05);
      chk("idle_g", 8'(g), 8'h3F);
      wq.other = 1;
      wait_act(n);
      chk("idle_lat", 8'(n), 8'h07);
      chk("done", 8'(done), 8'h01);
      wq = '0;
      tick(1);
      chk("done_end", 8'(done), 8'h00);
   endtask
   task automatic sc_stby();
      int n;
      rs = 5'h0C;
      drun = 1;
      sleep(2'h1);
      chk("stby_g", 8'(g), 8'h1F);
      chk("retain", 8'(ret), 8'h01);
      wq.uart_sof = 1;
      tick(3);
      chk("sof", 8'(st), 8'h04);
      osc = 0;
      wq.pin = 1;
      tick(8);
      chk("osc_wait", 8'(st), 8'h10);
      chk("wake_per", 8'(g.per), 8'h00);
      osc = 1;
      wait_act(n);
      chk("osc_go", 8'(n), 8'h01);
      wq = '0;
      drun = 0;
      tick(1);
      chk("resumes", res, 8'h02);
   endtask
   task automatic sc_pd();
      int n;
      sleep(2'h2);
      chk("pd_g", 8'(g), 8'h06);
      wq = 8'h3F;
      tick(4);
      chk("pd_hold", 8'(st), 8'h08);
      dbg = 1;
      wait_act(n);
      dbg = 0;
      wq = '0;
      chk("dbg", 8'(n), 8'h07);
   endtask
   task automatic sc_reset();
      sleep(2'h2);
      tick(20);
      chk("pd_stay", 8'(st), 8'h08);
      reset = 1;
      tick(1);
      reset = 0;
      chk("rst", 8'({st, halt}), 8'h02);
   endtask
   initial begin
      tick(3);
      reset = 0;
      sc_refuse();
      sc_idle();
      sc_stby();
      sc_pd();
      sc_reset();
      tally_and_finish();
   end
endmodule
